// ### rtl/clv_servo_defines.vh
/*
 Constants for the constant-linear-velocity spindle servo: mode codes,
 frame-width thresholds and phase-mode timing figures.
 Assumes inclusion by bare name from the servo module only.
*/
`ifndef CLV_SERVO_DEFINES_VH
`define CLV_SERVO_DEFINES_VH

// ----------------------------------------------------------------------
// Servo mode codes (servoModeReg)
// ----------------------------------------------------------------------
`define MODE_FORWARD   3'h0
`define MODE_REVERSE   3'h1
`define MODE_SPEED     3'h2
`define MODE_HSPEED    3'h3
`define MODE_PHASE     3'h4
`define MODE_AUTO      3'h5
`define MODE_VCO       3'h6
`define MODE_STOP      3'h7
`define MODE_RESET     3'h7

// ----------------------------------------------------------------------
// Frame sync widths, in VCO periods
// ----------------------------------------------------------------------
`define WIDTH_SHORT    8'h15
`define WIDTH_NOMINAL  8'h16
`define WIDTH_LONG     8'h17

// ----------------------------------------------------------------------
// Phase mode: high-period offset and scale of the phase pulse; automatic-mode lock sample and unlock count
// ----------------------------------------------------------------------
`define PHASE_OFFSET   12'h116
`define PHASE_SCALE    5
`define LOCK_SAMPLE    4'hf
`define UNLOCK_COUNT   4'h8

// ----------------------------------------------------------------------
// Hold clock dividers: peak hold /2,/4; bottom hold /16,/32; seek /256
// ----------------------------------------------------------------------
`define PEAK_DIV_LO    6'h01
`define PEAK_DIV_HI    6'h03
`define BOT_DIV_LO     6'h0f
`define BOT_DIV_HI     6'h1f
`define SEEK_DIV       8'hff

`endif

// ### rtl/clv_spindle_servo.v
/*
 Constant-linear-velocity spindle servo. Drives the four spindle outputs
 toward an external motor driver from the selected servo mode.
 Assumes all inputs are synchronous to sys_clk: frame strobes, VCO ticks
 and the crystal-based seek tick arrive as one-cycle enables or levels.
*/
`timescale 1ns/1ps
`include "clv_servo_defines.vh"

module clv_spindle_servo #(
   parameter WIDTH_BITS = 8,
   parameter COUNT_BITS = 12
) (
   // Clock, reset, enable
   input  wire       sys_clk,
   input  wire       rst,
   input  wire       clkEn,
   // Host settings
   input  wire [2:0] servoModeReg,
   input  wire       speedGain,
   input  wire       peakHoldSel,
   input  wire       bottomHoldSel,
   input  wire       phaseSourceSelect,
   // Timing sources
   input  wire       vcoTick,
   input  wire       vcoHalfTick,
   input  wire       crystalFrame,
   input  wire       playbackFrame,
   input  wire       readBaseFrame,
   input  wire       writeBaseFrame,
   input  wire       seekTick,
   input  wire       syncPulse,
   input  wire       syncCoincide,
   // Spindle outputs
   output reg        spindleDriveOut,
   output reg        spindleDriveOe,
   output reg        spindlePhaseOut,
   output reg        spindlePhaseOe,
   output reg        spindleFilterCtl,
   output reg        spindleMotorOn,
   output reg        frameLock,
   output reg        autoInPhase
);

   localparam ST_SPEED = 2'b01;
   localparam ST_PHASE = 2'b10;

   // ----------------------------------------------------------------------
   // Edge and divider helpers
   // ----------------------------------------------------------------------
   reg                  xtPrev_reg;
   reg                  pbPrev_reg;
   reg                  rbPrev_reg;
   reg                  wbPrev_reg;
   reg                  syncPrev_reg;
   reg [5:0]            xtDiv_reg;
   reg [7:0]            seekDiv_reg;
   reg [1:0]            xtQuarter_reg;
   reg [1:0]            pbQuarter_reg;
   wire                 xtRise = crystalFrame & ~xtPrev_reg;
   wire                 pbRise = playbackFrame & ~pbPrev_reg;
   wire                 pbFall = ~playbackFrame & pbPrev_reg;
   wire                 rbRise = readBaseFrame & ~rbPrev_reg;
   wire                 wbRise = writeBaseFrame & ~wbPrev_reg;
   wire                 syncFall = ~syncPulse & syncPrev_reg;
   wire                 vcoRef = (servoModeReg == `MODE_VCO);
   // The VCO-referenced mode replaces the crystal frame by the playback frame.
   wire                 refRise = vcoRef ? pbRise : xtRise;

   function divTick;
      input [5:0] cnt;
      input [5:0] lim;
      begin
         divTick = ((cnt & lim) == lim);
      end
   endfunction

   wire [5:0] peakLim = peakHoldSel ? `PEAK_DIV_HI : `PEAK_DIV_LO;
   wire [5:0] botLim  = bottomHoldSel ? `BOT_DIV_HI : `BOT_DIV_LO;
   wire       seekMode = (servoModeReg == `MODE_HSPEED);
   // The seek peak clock has its own slow divider: mirror bursts between
   // tracks must not stay held, whatever the frame reference is doing.
   wire       peakClk = seekMode ? (seekTick && seekDiv_reg == `SEEK_DIV)
                                 : (refRise && divTick(xtDiv_reg, peakLim));
   wire       botClk  = refRise && divTick(xtDiv_reg, botLim);

   // ----------------------------------------------------------------------
   // Frame sync width: peak hold and bottom hold
   // ----------------------------------------------------------------------
   reg [WIDTH_BITS-1:0] widthCnt_reg;
   reg [WIDTH_BITS-1:0] peak_reg;
   reg [WIDTH_BITS-1:0] held_reg;
   // A single long noise pulse only lifts the peak; the bottom hold clock
   // releases the held width, so mirror and noise widths decay away.
   always @(posedge sys_clk) begin
      if (rst) begin
         widthCnt_reg <= {WIDTH_BITS{1'b0}};
         peak_reg     <= {WIDTH_BITS{1'b0}};
         held_reg     <= `WIDTH_NOMINAL;
      end else if (clkEn) begin
         if (syncPulse && vcoTick)
            widthCnt_reg <= widthCnt_reg + 1'b1;
         else if (!syncPulse)
            widthCnt_reg <= {WIDTH_BITS{1'b0}};
         if (peakClk)
            peak_reg <= {WIDTH_BITS{1'b0}};
         else if (syncFall && widthCnt_reg > peak_reg)
            peak_reg <= widthCnt_reg;
         if (botClk)
            held_reg <= peak_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Phase comparison and phase pulse
   // ----------------------------------------------------------------------
   reg [COUNT_BITS-1:0] highCnt_reg;
   reg [COUNT_BITS-1:0] pulseCnt_reg;
   reg                  phaseUp_reg;
   reg                  phaseDn_reg;
   wire                 aQuarter = phaseSourceSelect ? rbRise : (pbRise && pbQuarter_reg == 2'h3);
   wire                 bQuarter = phaseSourceSelect ? wbRise : (refRise && xtQuarter_reg == 2'h3);
   wire [COUNT_BITS-1:0] excess = (highCnt_reg > `PHASE_OFFSET)
                                  ? highCnt_reg - `PHASE_OFFSET : {COUNT_BITS{1'b0}};

   always @(posedge sys_clk) begin
      if (rst) begin
         highCnt_reg  <= {COUNT_BITS{1'b0}};
         pulseCnt_reg <= {COUNT_BITS{1'b0}};
         phaseUp_reg  <= 1'b0;
         phaseDn_reg  <= 1'b0;
      end else if (clkEn) begin
         // The rising edge restarts the count with its own tick, so the count
         // at the falling edge is the whole high time of this frame only.
         if (pbRise)
            highCnt_reg <= {{(COUNT_BITS-1){1'b0}}, vcoHalfTick};
         else if (playbackFrame && vcoHalfTick)
            highCnt_reg <= highCnt_reg + 1'b1;
         if (pbFall)
            pulseCnt_reg <= (excess << `PHASE_SCALE);
         else if (pulseCnt_reg != {COUNT_BITS{1'b0}} && vcoHalfTick)
            pulseCnt_reg <= pulseCnt_reg - 1'b1;
         // Whichever quarter edge comes first opens the error window.
         if (aQuarter && bQuarter) begin
            phaseUp_reg <= 1'b0;
            phaseDn_reg <= 1'b0;
         end else if (aQuarter) begin
            if (phaseDn_reg) phaseDn_reg <= 1'b0;
            else phaseUp_reg <= 1'b1;
         end else if (bQuarter) begin
            if (phaseUp_reg) phaseUp_reg <= 1'b0;
            else phaseDn_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Automatic phase/speed selection and lock
   // ----------------------------------------------------------------------
   reg [1:0]            autoState_reg;
   reg [3:0]            frameCnt_reg;
   reg [3:0]            lowCnt_reg;
   reg                  gainPhase_reg;

   // The selector runs in every mode, so entering automatic mode starts
   // from a state that already reflects the recent lock history.

   always @(posedge sys_clk) begin
      if (rst) begin
         // Loading the pins here keeps a level that is already high at
         // release from looking like a fresh edge.
         xtPrev_reg    <= crystalFrame;
         pbPrev_reg    <= playbackFrame;
         rbPrev_reg    <= readBaseFrame;
         wbPrev_reg    <= writeBaseFrame;
         syncPrev_reg  <= syncPulse;
         xtDiv_reg     <= 6'h00;
         seekDiv_reg   <= 8'h00;
         xtQuarter_reg <= 2'h0;
         pbQuarter_reg <= 2'h0;
         autoState_reg <= ST_SPEED;
         frameCnt_reg  <= 4'h0;
         lowCnt_reg    <= 4'h0;
         gainPhase_reg <= 1'b0;
      end else if (clkEn) begin
         xtPrev_reg   <= crystalFrame;
         pbPrev_reg   <= playbackFrame;
         rbPrev_reg   <= readBaseFrame;
         wbPrev_reg   <= writeBaseFrame;
         syncPrev_reg <= syncPulse;
         if (refRise) xtDiv_reg <= xtDiv_reg + 1'b1;
         if (seekTick) seekDiv_reg <= seekDiv_reg + 1'b1;
         if (refRise) xtQuarter_reg <= xtQuarter_reg + 1'b1;
         if (pbRise) pbQuarter_reg <= pbQuarter_reg + 1'b1;
         gainPhase_reg <= ~gainPhase_reg;
         if (pbRise) begin
            frameCnt_reg <= frameCnt_reg + 1'b1;
            if (frameCnt_reg == `LOCK_SAMPLE) begin
               case (autoState_reg)
                  ST_SPEED: begin
                     if (frameLock) autoState_reg <= ST_PHASE;
                     lowCnt_reg <= 4'h0;
                  end
                  ST_PHASE: begin
                     if (frameLock)
                        lowCnt_reg <= 4'h0;
                     else if (lowCnt_reg == `UNLOCK_COUNT - 4'h1) begin
                        autoState_reg <= ST_SPEED;
                        lowCnt_reg    <= 4'h0;
                     end else
                        lowCnt_reg <= lowCnt_reg + 1'b1;
                  end
                  default: autoState_reg <= ST_SPEED;
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Output mode decode
   // ----------------------------------------------------------------------
   wire autoPhase = (autoState_reg == ST_PHASE);
   reg  drive_next;
   reg  driveOe_next;
   reg  phaseOut_next;
   reg  phaseOe_next;
   reg  motor_next;
   reg  speedMode;

   always @* begin
      drive_next    = 1'b0;
      driveOe_next  = 1'b1;
      phaseOut_next = 1'b0;
      phaseOe_next  = 1'b0;
      motor_next    = 1'b1;
      speedMode     = 1'b0;
      case (servoModeReg)
         `MODE_FORWARD: drive_next = 1'b1;
         `MODE_REVERSE: drive_next = 1'b0;
         `MODE_SPEED:   speedMode  = 1'b1;
         `MODE_HSPEED:  speedMode  = 1'b1;
         `MODE_PHASE: begin
            phaseOe_next = 1'b1;
         end
         `MODE_AUTO, `MODE_VCO: begin
            speedMode    = ~autoPhase;
            phaseOe_next = autoPhase;
         end
         default: motor_next = 1'b0;
      endcase
      if (speedMode) begin
         // Low gain drives only on alternate cycles: half duty, about -6 dB
         // less effort at the driver filter.
         if (held_reg < `WIDTH_SHORT) drive_next = 1'b0;
         else if (held_reg >= `WIDTH_LONG) drive_next = 1'b1;
         else driveOe_next = 1'b0;
         if (!speedGain && !gainPhase_reg) driveOe_next = 1'b0;
      end else if (phaseOe_next) begin
         drive_next    = phaseUp_reg;
         driveOe_next  = phaseUp_reg | phaseDn_reg;
         phaseOut_next = (pulseCnt_reg != {COUNT_BITS{1'b0}});
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         spindleDriveOut  <= 1'b0;
         spindleDriveOe   <= 1'b1;
         spindlePhaseOut  <= 1'b0;
         spindlePhaseOe   <= 1'b0;
         spindleFilterCtl <= 1'b0;
         spindleMotorOn   <= 1'b0;
         frameLock        <= 1'b0;
         autoInPhase      <= 1'b0;
      end else if (clkEn) begin
         spindleDriveOut  <= drive_next;
         spindleDriveOe   <= driveOe_next;
         spindlePhaseOut  <= phaseOut_next;
         spindlePhaseOe   <= phaseOe_next;
         spindleFilterCtl <= 1'b0;
         spindleMotorOn   <= motor_next;
         frameLock        <= syncCoincide;
         autoInPhase      <= autoPhase;
      end
   end

endmodule

// ### test/servo_timing_model.sv
/*
 Timing sources seen by the spindle servo: VCO ticks, crystal, playback and
 base frames, seek tick, a frame-sync pulse of set width and the lock level.
 Assumes the bench clock; every output changes just after the falling edge.
*/
`timescale 1ns/1ps
module servo_timing_model (
   // Bench clock and controls
   input  wire       sys_clk,
   input  wire [4:0] syncWidth,
   input  wire       lockIn,
   // Sources toward the servo
   output wire       vcoTick,
   output wire       vcoHalfTick,
   output wire       crystalFrame,
   output wire       playbackFrame,
   output wire       readBaseFrame,
   output wire       writeBaseFrame,
   output wire       seekTick,
   output wire       syncPulse,
   output wire       syncCoincide
);
   reg [8:0] pCnt = 9'h000;
   reg [5:0] xCnt = 6'h00;
   always @(negedge sys_clk) begin
      pCnt <= (pCnt == 9'h13f) ? 9'h000 : pCnt + 9'h001;
      xCnt <= xCnt + 6'h01;
   end
   // The playback frame is high for 282 half-VCO periods, so the phase pulse is 128 long.
   assign playbackFrame  = pCnt < 9'h11a;
   assign vcoHalfTick    = 1'b1;
   assign vcoTick        = ~xCnt[0];
   assign crystalFrame   = xCnt[5];
   assign readBaseFrame  = xCnt[4];
   assign writeBaseFrame = pCnt[5];
   assign seekTick       = xCnt[2:0] == 3'h0;
   // Starting on an even count puts exactly syncWidth VCO ticks inside the pulse.
   assign syncPulse      = xCnt >= 6'h02 && xCnt < {syncWidth, 1'b0} + 6'h02;
   assign syncCoincide   = lockIn;
endmodule

// ### test/clv_servo_checker.sv
/*
 Concurrent checks on the spindle servo outputs.
 Assumes binding to every clv_spindle_servo instance by port name.
*/
`timescale 1ns/1ps
module clv_servo_checker (
   // Clock, reset, enable
   input wire       sys_clk,
   input wire       rst,
   input wire       clkEn,
   // Inputs watched
   input wire [2:0] servoModeReg,
   input wire       syncCoincide,
   // Outputs watched
   input wire       spindleDriveOut,
   input wire       spindleDriveOe,
   input wire       spindlePhaseOe,
   input wire       spindleFilterCtl,
   input wire       spindleMotorOn,
   input wire       frameLock
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   reg       upd_reg = 1'b0;
   reg [2:0] mode_reg = 3'h7;
   always @(posedge sys_clk) begin
      upd_reg  <= !rst && clkEn;
      mode_reg <= servoModeReg;
   end
   chk_fwd_outputs: assert property (
      upd_reg && mode_reg == 3'h0 |-> spindleDriveOut && spindleDriveOe && !spindlePhaseOe
      && spindleMotorOn) else $error("Forward outputs wrong.");
   chk_rev_outputs: assert property (
      upd_reg && mode_reg == 3'h1 |-> !spindleDriveOut && spindleDriveOe && !spindlePhaseOe
      && spindleMotorOn) else $error("Reverse outputs wrong.");
   chk_stop_outputs: assert property (
      upd_reg && mode_reg == 3'h7 |-> !spindleDriveOut && spindleDriveOe && !spindlePhaseOe
      && !spindleMotorOn) else $error("Stop outputs wrong.");
   chk_speed_outputs: assert property (
      upd_reg && (mode_reg == 3'h2 || mode_reg == 3'h3) |-> spindleMotorOn && !spindlePhaseOe)
      else $error("Speed outputs wrong.");
   chk_phase_driven: assert property (
      upd_reg && mode_reg == 3'h4 |-> spindlePhaseOe) else $error("Phase output floats.");
   chk_reset_stop: assert property (
      $past(rst) |-> spindleDriveOe && !spindleDriveOut && !spindleMotorOn && !spindlePhaseOe
      && !frameLock) else $error("Reset state wrong.");
   chk_lock_follow: assert property (
      upd_reg |-> frameLock == $past(syncCoincide)) else $error("Lock flag wrong.");
   chk_filter_low: assert property (
      !spindleFilterCtl) else $error("Filter control high.");
   chk_enable_freeze: assert property (
      !$past(clkEn) && !$past(rst) |-> $stable(spindleDriveOut) && $stable(spindleMotorOn)
      && $stable(frameLock)) else $error("Outputs moved while disabled.");
endmodule
bind clv_spindle_servo clv_servo_checker chk (
   .sys_clk          (sys_clk),
   .rst              (rst),
   .clkEn            (clkEn),
   .servoModeReg     (servoModeReg),
   .syncCoincide     (syncCoincide),
   .spindleDriveOut  (spindleDriveOut),
   .spindleDriveOe   (spindleDriveOe),
   .spindlePhaseOe   (spindlePhaseOe),
   .spindleFilterCtl (spindleFilterCtl),
   .spindleMotorOn   (spindleMotorOn),
   .frameLock        (frameLock)
);

// ### test/tb_top.sv
/*
 Self-checking bench for the spindle servo: mode outputs, speed width control,
 phase pulse, automatic lock switching, enable freeze and reset.
 Assumes the timing model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
module tb_top;
   reg        sys_clk = 1'b0;
   reg        rst = 1'b1;
   reg        clkEn = 1'b1;
   reg  [2:0] servoModeReg = 3'h7;
   reg        speedGain = 1'b1;
   reg        peakHoldSel = 1'b0;
   reg        bottomHoldSel = 1'b0;
   reg        phaseSourceSelect = 1'b0;
   reg  [4:0] syncWidth = 5'h16;
   reg        lockIn = 1'b0;
   reg [11:0] e;
   wire vcoTick, vcoHalfTick, crystalFrame, playbackFrame, readBaseFrame, writeBaseFrame;
   wire seekTick, syncPulse, syncCoincide, autoInPhase, frameLock, spindleFilterCtl;
   wire spindleDriveOut, spindleDriveOe, spindlePhaseOut, spindlePhaseOe, spindleMotorOn;
   integer failCount = 0;
   integer nChecks = 0;
   integer i, cnt, hiCnt;
   // Mode, then expected drive, drive enable, phase enable, motor on.
   localparam [20:0] MTAB = {3'h0, 4'hd, 3'h1, 4'h5, 3'h7, 4'h4};
   // Mode, sync width, peak and bottom select, expected drive and drive enable.
   localparam [47:0] STAB = {3'h3, 5'h19, 4'hb, 3'h2, 5'h19, 4'h7, 3'h2, 5'h16, 4'hc,
                             3'h2, 5'h14, 4'h1};

   servo_timing_model MODEL (
      .sys_clk        (sys_clk),
      .syncWidth      (syncWidth),
      .lockIn         (lockIn),
      .vcoTick        (vcoTick),
      .vcoHalfTick    (vcoHalfTick),
      .crystalFrame   (crystalFrame),
      .playbackFrame  (playbackFrame),
      .readBaseFrame  (readBaseFrame),
      .writeBaseFrame (writeBaseFrame),
      .seekTick       (seekTick),
      .syncPulse      (syncPulse),
      .syncCoincide   (syncCoincide)
   );
   clv_spindle_servo DUT (
      .sys_clk           (sys_clk),
      .rst               (rst),
      .clkEn             (clkEn),
      .servoModeReg      (servoModeReg),
      .speedGain         (speedGain),
      .peakHoldSel       (peakHoldSel),
      .bottomHoldSel     (bottomHoldSel),
      .phaseSourceSelect (phaseSourceSelect),
      .vcoTick           (vcoTick),
      .vcoHalfTick       (vcoHalfTick),
      .crystalFrame      (crystalFrame),
      .playbackFrame     (playbackFrame),
      .readBaseFrame     (readBaseFrame),
      .writeBaseFrame    (writeBaseFrame),
      .seekTick          (seekTick),
      .syncPulse         (syncPulse),
      .syncCoincide      (syncCoincide),
      .spindleDriveOut   (spindleDriveOut),
      .spindleDriveOe    (spindleDriveOe),
      .spindlePhaseOut   (spindlePhaseOut),
      .spindlePhaseOe    (spindlePhaseOe),
      .spindleFilterCtl  (spindleFilterCtl),
      .spindleMotorOn    (spindleMotorOn),
      .frameLock         (frameLock),
      .autoInPhase       (autoInPhase)
   );

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   task chkBit(input logic got, input logic exp);
      begin
         nChecks = nChecks + 1;
         if (got !== exp) begin
            failCount = failCount + 1;
            $display("[ERR] %0t output got %b expected %b", $time, got, exp);
         end
      end
   endtask

   task chkRange(input integer got, input integer lo, input integer hi);
      begin
         nChecks = nChecks + 1;
         if (got < lo || got > hi) begin
            failCount = failCount + 1;
            $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
         end
      end
   endtask

   task setMode(input [2:0] m, input integer n);
      begin
         @(negedge sys_clk);
         servoModeReg = m;
         repeat (n) @(negedge sys_clk);
      end
   endtask

   task complete_run;
      begin
         $display("Checks %0d, mismatches %0d", nChecks, failCount);
         if (failCount == 0 && nChecks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
         setMode(MTAB[i*7+4 +: 3], 3);
         chkBit(spindleDriveOut, MTAB[i*7+3]);
         chkBit(spindleDriveOe, MTAB[i*7+2]);
         chkBit(spindlePhaseOe, MTAB[i*7+1]);
         chkBit(spindleMotorOn, MTAB[i*7]);
      end
      clkEn = 1'b0;
      setMode(3'h7, 4);
      chkBit(spindleMotorOn, 1'b1);
      clkEn = 1'b1;
      repeat (2) @(negedge sys_clk);
      chkBit(spindleMotorOn, 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
         e = STAB[i*12 +: 12];
         syncWidth = e[8:4];
         peakHoldSel = e[3];
         bottomHoldSel = e[2];
         setMode(e[11:9], 4500);
         chkBit(spindleDriveOe, e[0]);
         if (e[0]) chkBit(spindleDriveOut, e[1]);
      end
      speedGain = 1'b0;
      setMode(3'h2, 4500);
      cnt = 0;
      repeat (64) begin
         @(negedge sys_clk);
         if (spindleDriveOe === 1'b0) cnt = cnt + 1;
      end
      chkRange(cnt, 30, 34);
      speedGain = 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
         phaseSourceSelect = i[0];
         setMode(3'h4, 1000);
         cnt = 0;
         hiCnt = 0;
         repeat (320) begin
            @(negedge sys_clk);
            if (spindlePhaseOut === 1'b1) cnt = cnt + 1;
            if (spindleDriveOut === 1'b1 && spindleDriveOe === 1'b1) hiCnt = hiCnt + 1;
         end
         chkRange(cnt, 126, 130);
         // A slower first source never pushes the drive high; a faster one mostly does.
         chkRange(hiCnt, i * 160, i * 320);
      end
      lockIn = 1'b1;
      setMode(3'h5, 5440);
      chkBit(autoInPhase, 1'b1);
      lockIn = 1'b0;
      repeat (30720) @(negedge sys_clk);
      chkBit(autoInPhase, 1'b1);
      repeat (16000) @(negedge sys_clk);
      chkBit(autoInPhase, 1'b0);
      setMode(3'h6, 200);
      chkBit(spindleMotorOn, 1'b1);
      rst = 1'b1;
      repeat (8) @(negedge sys_clk);
      chkBit(spindleMotorOn, 1'b0);
      chkBit(spindleDriveOe, 1'b1);
      rst = 1'b0;
      complete_run;
   end

   // The tests need about 78000 cycles; the limit of 90000 keeps the run short.
   initial begin
      #450000;
      failCount = failCount + 1;
      complete_run;
   end
endmodule
